// ### hw/msd_pkg.sv
package msd_pkg;
    // ========================================
    // register map
    localparam logic [7:0]  STARTUP_TWO_ADDR    = 8'h84;
    localparam logic [7:0]  CLOSED_LOOP_ONE_ADDR = 8'h88;
    localparam logic [31:0] STARTUP_TWO_RESET   = 32'h0000_0000;
    // undefined reset value is modelled as zero so simulation starts known
    localparam logic [31:0] CLOSED_LOOP_ONE_RESET = 32'h0000_0000;
    // ========================================
    // field positions in startup_settings_two
    localparam int RAMP_LSB   = 0;
    localparam int RAMP_W     = 3;
    localparam int SRC_BIT    = 3;
    localparam int PCT_LSB    = 4;
    localparam int PCT_W      = 4;
    localparam int ALIGN_LSB  = 8;
    localparam int ALIGN_W    = 5;
    localparam logic [4:0] ALIGN_LAST_CODE = 5'h1C;
    // ========================================
    // decoded units: percent x10, degrees, milli-deg per ms
    localparam logic [9:0] PCT_X10_TABLE [16] = '{
        10'h00A, 10'h014, 10'h01E, 10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096,
        10'h0AF, 10'h0C8, 10'h0FA, 10'h12C, 10'h15E, 10'h190, 10'h1C2, 10'h1F4};
    localparam logic [11:0] RAMP_MDEG_TABLE [8] = '{
        12'h00A, 12'h032, 12'h064, 12'h096, 12'h0C8, 12'h1F4, 12'h3E8, 12'h7D0};
    localparam logic [8:0] ALIGN_DEG_TABLE [29] = '{
        9'h000, 9'h00A, 9'h014, 9'h01E, 9'h02D, 9'h03C, 9'h046, 9'h050,
        9'h05A, 9'h06E, 9'h078, 9'h087, 9'h096, 9'h0A0, 9'h0AA, 9'h0B4,
        9'h0BE, 9'h0D2, 9'h0E1, 9'h0F0, 9'h0FA, 9'h104, 9'h10E, 9'h118,
        9'h122, 9'h13B, 9'h14A, 9'h154, 9'h15E};
endpackage : msd_pkg

// ### hw/msd_speed_decode.sv
`timescale 1ns/1ps
`default_nettype none
module msd_speed_decode (
    input  wire logic [3:0] pct_code,
    input  wire logic       source_zero,
    output logic      [9:0] pct_x10
);
    always_comb begin
        if (source_zero) begin
            pct_x10 = 10'h000;
        end else begin
            pct_x10 = msd_pkg::PCT_X10_TABLE[pct_code];
        end
    end
endmodule : msd_speed_decode
`default_nettype wire

// ### hw/msd_angle_decode.sv
`timescale 1ns/1ps
`default_nettype none
module msd_angle_decode (
    input  wire logic [4:0]  align_code,
    input  wire logic [2:0]  ramp_code,
    output logic      [8:0]  align_deg,
    output logic             align_bad,
    output logic      [11:0] ramp_mdeg
);
    always_comb begin
        // reserved codes hold angle at zero and raise a flag
        if (align_code > msd_pkg::ALIGN_LAST_CODE) begin
            align_deg = 9'h000;
            align_bad = 1'b1;
        end else begin
            align_deg = msd_pkg::ALIGN_DEG_TABLE[align_code];
            align_bad = 1'b0;
        end
        ramp_mdeg = msd_pkg::RAMP_MDEG_TABLE[ramp_code];
    end
endmodule : msd_angle_decode
`default_nettype wire

// ### hw/msd_top.sv
`timescale 1ns/1ps
`default_nettype none
module msd_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic      [9:0]  initial_cycle_speed_pct,
    output logic             initial_cycle_speed_source,
    output logic      [8:0]  align_angle_deg,
    output logic             align_code_reserved,
    output logic      [11:0] ramp_rate_mdeg_per_ms,
    output logic      [31:0] closed_loop_settings_one
);
    logic [31:0] startup_two_ff;
    logic [31:0] closed_one_ff;
    logic [31:0] rdata_ff;
    logic [9:0]  nxt_pct;
    logic [8:0]  nxt_align;
    logic        nxt_bad;
    logic [11:0] nxt_ramp;
    logic [9:0]  pct_ff;
    logic        src_ff;
    logic [8:0]  align_ff;
    logic        bad_ff;
    logic [11:0] ramp_ff;
    // ========================================
    // register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startup_two_ff <= msd_pkg::STARTUP_TWO_RESET;
        end else if (ce && wr && addr == msd_pkg::STARTUP_TWO_ADDR) begin
            startup_two_ff <= wdata;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            closed_one_ff <= msd_pkg::CLOSED_LOOP_ONE_RESET;
        end else if (ce && wr && addr == msd_pkg::CLOSED_LOOP_ONE_ADDR) begin
            closed_one_ff <= wdata;
        end
    end
    // ========================================
    // read port, data one cycle after strobe; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            if (!rd) begin
                rdata_ff <= 32'h0000_0000;
            end else if (addr == msd_pkg::STARTUP_TWO_ADDR) begin
                rdata_ff <= startup_two_ff;
            end else if (addr == msd_pkg::CLOSED_LOOP_ONE_ADDR) begin
                rdata_ff <= closed_one_ff;
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end
    // ========================================
    // field decode
    msd_speed_decode u_speed (
        .pct_code    (startup_two_ff[msd_pkg::PCT_LSB +: msd_pkg::PCT_W]),
        .source_zero (startup_two_ff[msd_pkg::SRC_BIT]),
        .pct_x10     (nxt_pct)
    );
    msd_angle_decode u_angle (
        .align_code (startup_two_ff[msd_pkg::ALIGN_LSB +: msd_pkg::ALIGN_W]),
        .ramp_code  (startup_two_ff[msd_pkg::RAMP_LSB +: msd_pkg::RAMP_W]),
        .align_deg  (nxt_align),
        .align_bad  (nxt_bad),
        .ramp_mdeg  (nxt_ramp)
    );
    // decoded outputs registered so they lag a write by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pct_ff   <= 10'h000;
            src_ff   <= 1'b0;
            align_ff <= 9'h000;
            bad_ff   <= 1'b0;
            ramp_ff  <= 12'h000;
        end else if (ce) begin
            pct_ff   <= nxt_pct;
            src_ff   <= startup_two_ff[msd_pkg::SRC_BIT];
            align_ff <= nxt_align;
            bad_ff   <= nxt_bad;
            ramp_ff  <= nxt_ramp;
        end
    end
    assign rdata                      = rdata_ff;
    assign initial_cycle_speed_pct    = pct_ff;
    assign initial_cycle_speed_source = src_ff;
    assign align_angle_deg            = align_ff;
    assign align_code_reserved        = bad_ff;
    assign ramp_rate_mdeg_per_ms      = ramp_ff;
    assign closed_loop_settings_one   = closed_one_ff;
endmodule : msd_top
`default_nettype wire

// ### test/msd_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module msd_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [9:0]  initial_cycle_speed_pct,
    input wire logic        initial_cycle_speed_source,
    input wire logic [8:0]  align_angle_deg,
    input wire logic        align_code_reserved,
    input wire logic [11:0] ramp_rate_mdeg_per_ms,
    input wire logic [31:0] closed_loop_settings_one
);
    // ====================
    // decode and bus checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // decoded fields land one edge after the write edge
    sequence s_w;
        ce && wr && addr == 8'h84 ##1 ce;
    endsequence
    a_pct_decode: assert property (s_w |=> initial_cycle_speed_pct == ($past(wdata[3], 2) ? 10'h000
        : msd_pkg::PCT_X10_TABLE[$past(wdata[7:4], 2)])) else $error("speed decode wrong");
    a_src_follow: assert property (s_w |=> initial_cycle_speed_source == $past(wdata[3], 2))
        else $error("source bit wrong");
    a_pct_live: assert property (s_w ##1 !initial_cycle_speed_source |-> initial_cycle_speed_pct != 0)
        else $error("speed zero while percentage selected");
    a_ramp_decode: assert property (s_w |=> ramp_rate_mdeg_per_ms
        == msd_pkg::RAMP_MDEG_TABLE[$past(wdata[2:0], 2)]) else $error("ramp decode wrong");
    a_align_resv: assert property (s_w |=> align_code_reserved == ($past(wdata[12:8], 2) > 5'h1C))
        else $error("reserved flag wrong");
    a_cl_write: assert property (ce && wr && addr == 8'h88 |=> closed_loop_settings_one == $past(wdata))
        else $error("closed loop register not written");
    a_rd_idle: assert property (ce && !rd |=> rdata == 32'h0000_0000)
        else $error("read data not idle");
    a_rd_data: assert property (ce && rd && addr == 8'h88 |=> rdata == $past(closed_loop_settings_one))
        else $error("closed loop read data wrong");
    // a low enable must freeze read data, the closed loop register and the speed and ramp outputs
    a_ce_freeze: assert property (!ce |=> $stable(rdata) && $stable(closed_loop_settings_one)
        && $stable(initial_cycle_speed_pct) && $stable(ramp_rate_mdeg_per_ms))
        else $error("state moved while enable low");
    c_src: cover property (s_w ##1 initial_cycle_speed_source);
    c_resv: cover property (s_w ##1 align_code_reserved);
    c_rd: cover property (rd && addr == 8'h88 ##1 rdata != 0);
endmodule : msd_chk
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, src, resv;
    logic [7:0]  addr = 0;
    logic [31:0] wdata = 0, rdata, cl;
    logic [9:0]  pct;
    logic [8:0]  ang;
    logic [11:0] ramp;
    int          n_errors = 0, comparisons = 0, cyc = 0;
    always #4 clk = ~clk;
    msd_top uut (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .initial_cycle_speed_pct(pct),
        .initial_cycle_speed_source(src), .align_angle_deg(ang), .align_code_reserved(resv),
        .ramp_rate_mdeg_per_ms(ramp), .closed_loop_settings_one(cl));
    // ====================
    // wrap-up, check and bus tasks
    task wrap_up;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask : wreg
    task rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a; rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask : rchk
    // decoded outputs settle one edge after the write edge
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        rchk(8'h84, 32'h0);
        rchk(8'h88, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 32; i++) wreg(8'h84, 32'({i[4:0], i[3:0], i[1], i[2:0]}));
        wreg(8'h84, 32'h1CF7);
        settle();
        chk(32'(pct), 32'h1F4);
        chk(32'(ang), 32'h15E);
        chk(32'(ramp), 32'h7D0);
        wreg(8'h84, 32'h1D08);
        settle();
        chk({src, resv, 30'(pct)}, 32'hC000_0000);
        chk(32'(ramp), 32'h00A);
        wreg(8'h84, 32'h0050);
        settle();
        chk(32'(pct), 32'h064);
        $display("test decode done");
        wreg(8'h88, 32'hA5A5_5A5A);
        #1 chk(cl, 32'hA5A5_5A5A);
        rchk(8'h88, 32'hA5A5_5A5A);
        wreg(8'h40, 32'hFFFF_FFFF);
        rchk(8'h40, 32'h0);
        rchk(8'h84, 32'h0050);
        $display("test bus done");
        @(posedge clk);
        ce <= 1'b0;
        wreg(8'h88, 32'h0000_FFFF);
        wreg(8'h84, 32'h0000_1F0F);
        settle();
        chk(cl, 32'hA5A5_5A5A);
        chk(32'(pct), 32'h064);
        ce <= 1'b1;
        rchk(8'h84, 32'h0000_0050);
        $display("test enable done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk(cl, 32'h0);
        rchk(8'h84, 32'h0);
        settle();
        chk({22'(ramp), pct}, {22'h00A, 10'h00A});
        chk(32'(ang), 32'h0);
        $display("test mid reset done");
        wrap_up();
    end
endmodule : tb
bind msd_top msd_chk u_chk (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .initial_cycle_speed_pct,
    .initial_cycle_speed_source, .align_angle_deg, .align_code_reserved, .ramp_rate_mdeg_per_ms,
    .closed_loop_settings_one);
`default_nettype wire
